// ---- lqm_defines.svh ----
`ifndef LQM_DEFINES_SVH
`define LQM_DEFINES_SVH

// timing
`define LQM_CLK_HZ          10000000
`define LQM_IDLE_TIMEOUT_MS 1000
`define LQM_IDLE_CYC        (`LQM_IDLE_TIMEOUT_MS * (`LQM_CLK_HZ / 1000))
`define LQM_CHECK_DIV       32
`define LQM_TICK_US         (1000000 / `LQM_CHECK_DIV)
`define LQM_TICK_CYC        (`LQM_TICK_US * (`LQM_CLK_HZ / 1000000))
`define LQM_ECHO_PPS        500
`define LQM_ECHO_CYC        (`LQM_CLK_HZ / `LQM_ECHO_PPS)

// setting limits and reset values
`define LQM_QLVL_MIN        7'h0A
`define LQM_QLVL_MAX        7'h63
`define LQM_QLVL_RST        7'h5A
`define LQM_WIN_MIN         9'h00A
`define LQM_WIN_MAX         9'h190
`define LQM_WIN_RST         9'h01E
`define LQM_PCT_FULL        7'h64
`define LQM_RESTORE_NUM     6
`define LQM_RESTORE_DEN     10

// register offsets
`define LQM_REG_CTRL        8'h00
`define LQM_REG_QLVL        8'h04
`define LQM_REG_WIN         8'h08
`define LQM_REG_DEST        8'h0C
`define LQM_REG_RATE        8'h10
`define LQM_REG_STATUS      8'h14
`define LQM_REG_IRQ_STAT    8'h18
`define LQM_REG_IRQ_MASK    8'h1C

// field positions
`define LQM_CTRL_MODE_LSB   0
`define LQM_CTRL_EN_BIT     2
`define LQM_CTRL_PAGE_BIT   3
`define LQM_CTRL_SRST_BIT   4
`define LQM_MODE_OFF        2'h0
`define LQM_MODE_ON         2'h3
`define LQM_IRQ_SVC_BIT     0
`define LQM_IRQ_LINK_BIT    1
`define LQM_IRQ_CHECK_BIT   2
`define LQM_IRQ_W           3

`endif

// ---- lqm_pkg.sv ----
package lqm_pkg;

   typedef enum logic [1:0] {
      LQM_ST_IDLE,
      LQM_ST_NEG,
      LQM_ST_ON
   } lqm_link_t;

   typedef struct packed {
      lqm_link_t   st;
      logic [1:0]  mode;
      logic        lqm_en;
      logic        page_4k;
      logic [6:0]  qual_lvl;
      logic [8:0]  win;
      logic [15:0] dest;
      logic [15:0] rate;
      logic [2:0]  ista;
      logic [2:0]  imask;
      logic        svc;
      logic        checked;
      logic [23:0] idle_cnt;
      logic [23:0] tick_cnt;
      logic [14:0] echo_cnt;
      logic [8:0]  win_cnt;
      logic [15:0] tx_pkts;
      logic [15:0] tx_bytes;
      logic [15:0] rx_pkts;
      logic [15:0] rx_bytes;
      logic [15:0] r_rx_pkts;
      logic [15:0] r_rx_bytes;
      logic [15:0] r_tx_pkts;
      logic [15:0] r_tx_bytes;
      logic [3:0]  bad;
      logic        send_query;
      logic        send_echo;
      logic [15:0] echo_len;
      logic [31:0] rdata;
   } lqm_state_t;

endpackage

// ---- lqm_loss_chk.sv ----
`timescale 1ns/10ps
`include "lqm_defines.svh"

module lqm_loss_chk #(
   parameter int CW = 16
) (
   input  wire logic [CW-1:0] sent,
   input  wire logic [CW-1:0] got,
   input  wire logic [6:0]    allowed,
   output logic               bad,
   output logic               good
);
   localparam int PW = CW + 12;

   logic [CW-1:0] lost;
   logic [PW-1:0] lost_w;
   logic [PW-1:0] sent_w;
   logic [PW-1:0] allow_w;

   if (CW < 1 || CW > 20) begin : g_chk
      $error("lqm_loss_chk: CW out of range");
   end

   // a far end that reports more than was sent counts as no loss
   assign lost    = (sent > got) ? (sent - got) : '0;
   assign lost_w  = PW'(lost);
   assign sent_w  = PW'(sent);
   assign allow_w = PW'(allowed);
   // compare by cross multiplication; no divider needed
   assign bad  = (sent != '0) &&
                 ((lost_w * PW'(`LQM_PCT_FULL)) >= (allow_w * sent_w));
   assign good = (sent == '0) ||
                 ((lost_w * PW'(`LQM_PCT_FULL) * PW'(`LQM_RESTORE_DEN)) <=
                  (allow_w * PW'(`LQM_RESTORE_NUM) * sent_w));
endmodule

// ---- lqm_top.sv ----
`timescale 1ns/10ps
`include "lqm_defines.svh"

module lqm_top
   import lqm_pkg::*;
#(
   parameter int unsigned IDLE_CYC = `LQM_IDLE_CYC,
   parameter int unsigned TICK_CYC = `LQM_TICK_CYC,
   parameter int unsigned ECHO_CYC = `LQM_ECHO_CYC
) (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        nucleus_reset,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata,
   input  wire logic        link_activity,
   input  wire logic        qr_valid,
   input  wire logic        qr_page_4k,
   input  wire logic        qr_looped,
   input  wire logic [15:0] qr_dest,
   input  wire logic [15:0] qr_rx_pkts,
   input  wire logic [15:0] qr_rx_bytes,
   input  wire logic [15:0] qr_tx_pkts,
   input  wire logic [15:0] qr_tx_bytes,
   input  wire logic        tx_pkt_done,
   input  wire logic [15:0] tx_pkt_len,
   input  wire logic        rx_pkt_done,
   input  wire logic [15:0] rx_pkt_len,
   output logic             send_query,
   output logic             send_echo,
   output logic [15:0]      echo_len,
   output logic             link_on,
   output logic             in_service,
   output logic             saturating,
   output logic             irq
);
   if (IDLE_CYC < 2 || IDLE_CYC >= (1 << 24) || TICK_CYC < 2 || TICK_CYC >= (1 << 24) ||
       ECHO_CYC < 2 || ECHO_CYC >= (1 << 15)) begin : g_chk
      $error("lqm_top: timing parameter out of range");
   end

   localparam lqm_state_t RST = '{st: LQM_ST_IDLE, mode: `LQM_MODE_OFF, qual_lvl: `LQM_QLVL_RST,
                                  win: `LQM_WIN_RST, default: '0};

   lqm_state_t  s_q;
   lqm_state_t  s_d;
   logic [15:0] sent_v [4];
   logic [15:0] got_v  [4];
   logic [3:0]  bad_v;
   logic [3:0]  good_v;
   logic [6:0]  allowed;
   logic        tick;
   logic        check;
   logic        qr_ok;
   logic        soft_rst;
   logic        wr_ctrl;
   logic        wr_qlvl;
   logic        wr_win;
   logic        sat;
   logic [2:0]  ev;
   logic [2:0]  w1c;

   function automatic logic [15:0] lqm_sat_add(input logic [15:0] a, input logic [15:0] b);
      logic [16:0] sum;
      sum = {1'b0, a} + {1'b0, b};
      return sum[16] ? 16'hFFFF : sum[15:0];
   endfunction

   assign allowed = `LQM_PCT_FULL - s_q.qual_lvl;

   // tx losses: what we sent against what the far end saw; rx the other way round
   assign sent_v[0] = s_q.tx_pkts;
   assign got_v[0]  = s_q.r_rx_pkts;
   assign sent_v[1] = s_q.tx_bytes;
   assign got_v[1]  = s_q.r_rx_bytes;
   assign sent_v[2] = s_q.r_tx_pkts;
   assign got_v[2]  = s_q.rx_pkts;
   assign sent_v[3] = s_q.r_tx_bytes;
   assign got_v[3]  = s_q.rx_bytes;

   for (genvar i = 0; i < 4; i++) begin : g_loss
      lqm_loss_chk #(
         .CW      (16)
      ) u_loss (
         .sent    (sent_v[i]),
         .got     (got_v[i]),
         .allowed (allowed),
         .bad     (bad_v[i]),
         .good    (good_v[i])
      );
   end

   assign tick     = (s_q.tick_cnt == 24'(TICK_CYC - 1));
   // window of w counted in 1/32 s ticks gives a period of w/32 s
   assign check    = tick && (s_q.win_cnt == (s_q.win - 9'h001));
   assign qr_ok    = qr_valid && (qr_page_4k == s_q.page_4k) && !qr_looped &&
                     ((s_q.dest == 16'h0000) || (s_q.dest == qr_dest));
   assign soft_rst = nucleus_reset ||
                     (reg_wr && reg_addr == `LQM_REG_CTRL && reg_wdata[`LQM_CTRL_SRST_BIT]);
   assign wr_ctrl  = reg_wr && reg_addr == `LQM_REG_CTRL;
   assign wr_qlvl  = reg_wr && reg_addr == `LQM_REG_QLVL;
   assign wr_win   = reg_wr && reg_addr == `LQM_REG_WIN;
   assign sat      = (s_q.st == LQM_ST_ON) && s_q.lqm_en && s_q.checked && !s_q.svc;
   assign w1c      = (reg_wr && reg_addr == `LQM_REG_IRQ_STAT) ? reg_wdata[2:0] : 3'h0;

   always_comb begin
      s_d            = s_q;
      ev             = 3'h0;
      s_d.send_query = 1'b0;
      s_d.send_echo  = 1'b0;
      s_d.rdata      = 32'h0000_0000;

      // register writes
      if (wr_ctrl) begin
         s_d.mode    = reg_wdata[`LQM_CTRL_MODE_LSB +: 2];
         s_d.lqm_en  = reg_wdata[`LQM_CTRL_EN_BIT];
         s_d.page_4k = reg_wdata[`LQM_CTRL_PAGE_BIT];
      end
      // out of range settings are dropped and the old value stays
      if (wr_qlvl && reg_wdata[31:7] == '0 && reg_wdata[6:0] >= `LQM_QLVL_MIN &&
          reg_wdata[6:0] <= `LQM_QLVL_MAX) begin
         s_d.qual_lvl = reg_wdata[6:0];
      end
      if (wr_win && reg_wdata[31:9] == '0 && reg_wdata[8:0] >= `LQM_WIN_MIN &&
          reg_wdata[8:0] <= `LQM_WIN_MAX) begin
         s_d.win = reg_wdata[8:0];
      end
      if (reg_wr && reg_addr == `LQM_REG_DEST) begin
         s_d.dest = reg_wdata[15:0];
      end
      if (reg_wr && reg_addr == `LQM_REG_RATE) begin
         s_d.rate = reg_wdata[15:0];
      end
      if (reg_wr && reg_addr == `LQM_REG_IRQ_MASK) begin
         s_d.imask = reg_wdata[2:0];
      end

      // free running 1/32 s divider
      s_d.tick_cnt = tick ? 24'h00_0000 : s_q.tick_cnt + 24'h00_0001;

      // activity watchdog
      if (link_activity || qr_valid) begin
         s_d.idle_cnt = 24'h00_0000;
      end else if (s_q.idle_cnt != 24'(IDLE_CYC)) begin
         s_d.idle_cnt = s_q.idle_cnt + 24'h00_0001;
      end

      // link state
      case (s_q.st)
         LQM_ST_IDLE: begin
            if (s_q.mode == `LQM_MODE_ON) begin
               s_d.st = LQM_ST_NEG;
            end
         end
         LQM_ST_NEG: begin
            if (s_q.mode != `LQM_MODE_ON) begin
               s_d.st = LQM_ST_IDLE;
            end else if (qr_ok) begin
               s_d.st = LQM_ST_ON;
               ev[`LQM_IRQ_LINK_BIT] = 1'b1;
            end
            if (tick) begin
               s_d.send_query = 1'b1;
            end
         end
         LQM_ST_ON: begin
            if (s_q.mode != `LQM_MODE_ON) begin
               s_d.st = LQM_ST_IDLE;
               ev[`LQM_IRQ_LINK_BIT] = 1'b1;
            end else if (s_q.idle_cnt == 24'(IDLE_CYC) && !link_activity && !qr_valid) begin
               s_d.st = LQM_ST_NEG;
               ev[`LQM_IRQ_LINK_BIT] = 1'b1;
            end
            if (tick && s_q.lqm_en) begin
               s_d.send_query = 1'b1;
            end
         end
         default: begin
            s_d.st = LQM_ST_IDLE;
         end
      endcase

      // statistics, gathered over one check period
      if (tx_pkt_done) begin
         s_d.tx_pkts  = lqm_sat_add(s_q.tx_pkts, 16'h0001);
         s_d.tx_bytes = lqm_sat_add(s_q.tx_bytes, tx_pkt_len);
      end
      if (rx_pkt_done) begin
         s_d.rx_pkts  = lqm_sat_add(s_q.rx_pkts, 16'h0001);
         s_d.rx_bytes = lqm_sat_add(s_q.rx_bytes, rx_pkt_len);
      end
      if (qr_ok && s_q.lqm_en) begin
         s_d.r_rx_pkts  = qr_rx_pkts;
         s_d.r_rx_bytes = qr_rx_bytes;
         s_d.r_tx_pkts  = qr_tx_pkts;
         s_d.r_tx_bytes = qr_tx_bytes;
      end

      // acceptability check and service state
      if (s_q.st != LQM_ST_ON) begin
         s_d.svc     = 1'b0;
         s_d.checked = 1'b0;
         s_d.win_cnt = 9'h000;
      end else if (!s_q.lqm_en) begin
         s_d.svc     = 1'b1;
         s_d.checked = 1'b0;
         s_d.win_cnt = 9'h000;
      end else if (tick) begin
         s_d.win_cnt = check ? 9'h000 : s_q.win_cnt + 9'h001;
         if (check) begin
            ev[`LQM_IRQ_CHECK_BIT] = 1'b1;
            s_d.bad      = bad_v;
            s_d.checked  = 1'b1;
            s_d.tx_pkts  = 16'h0000;
            s_d.tx_bytes = 16'h0000;
            s_d.rx_pkts  = 16'h0000;
            s_d.rx_bytes = 16'h0000;
            if (s_q.svc) begin
               s_d.svc = !(|bad_v);
            end else if (!s_q.checked) begin
               s_d.svc = !(|bad_v);
            end else begin
               s_d.svc = &good_v;
            end
         end
      end
      // switching the monitor off must not leave a stale checked flag for one cycle
      if (!s_d.lqm_en) begin
         s_d.checked = 1'b0;
      end
      if (s_d.svc != s_q.svc) begin
         ev[`LQM_IRQ_SVC_BIT] = 1'b1;
      end

      // line saturation while degraded
      if (sat) begin
         if (s_q.echo_cnt == 15'(ECHO_CYC - 1)) begin
            s_d.echo_cnt  = 15'h0000;
            s_d.send_echo = 1'b1;
         end else begin
            s_d.echo_cnt = s_q.echo_cnt + 15'h0001;
         end
      end else begin
         s_d.echo_cnt = 15'h0000;
      end
      // rate in kbit/s; one frame per 2 ms carries rate/4 bytes
      s_d.echo_len = {2'b00, s_q.rate[15:2]};

      // sticky events; a new event wins over a same-cycle clear
      s_d.ista = (s_q.ista & ~w1c) | ev;

      // read data stand in the cycle after the strobe only
      if (reg_rd) begin
         case (reg_addr)
            `LQM_REG_CTRL:     s_d.rdata = {28'h0, s_q.page_4k, s_q.lqm_en, s_q.mode};
            `LQM_REG_QLVL:     s_d.rdata = {25'h0, s_q.qual_lvl};
            `LQM_REG_WIN:      s_d.rdata = {23'h0, s_q.win};
            `LQM_REG_DEST:     s_d.rdata = {16'h0, s_q.dest};
            `LQM_REG_RATE:     s_d.rdata = {16'h0, s_q.rate};
            `LQM_REG_STATUS:   s_d.rdata = {25'h0, s_q.bad, sat, s_q.svc,
                                            s_q.st == LQM_ST_ON};
            `LQM_REG_IRQ_STAT: s_d.rdata = {29'h0, s_q.ista};
            `LQM_REG_IRQ_MASK: s_d.rdata = {29'h0, s_q.imask};
            default:           s_d.rdata = 32'h0000_0000;
         endcase
      end

      if (soft_rst) begin
         s_d = RST;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q <= RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata  = s_q.rdata;
   assign send_query = s_q.send_query;
   assign send_echo  = s_q.send_echo;
   assign echo_len   = s_q.echo_len;
   assign link_on    = (s_q.st == LQM_ST_ON);
   assign in_service = s_q.svc;
   assign saturating = sat;
   assign irq        = |(s_q.ista & s_q.imask);

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   property p_query_neg;
      (s_q.st == LQM_ST_NEG) && tick && !soft_rst |=> send_query;
   endproperty
   a_query_neg: assert property (p_query_neg) else $error("no query while negotiating");

   property p_idle_drop;
      link_on && (s_q.idle_cnt == 24'(IDLE_CYC)) && !link_activity && !qr_valid |=> !link_on;
   endproperty
   a_idle_drop: assert property (p_idle_drop) else $error("idle link stayed on");

   property p_qr_on;
      (s_q.st == LQM_ST_NEG) && (s_q.mode == `LQM_MODE_ON) && qr_ok && !soft_rst |=> link_on;
   endproperty
   a_qr_on: assert property (p_qr_on) else $error("valid response did not bring link on");

   property p_qr_bad;
      (s_q.st == LQM_ST_NEG) && qr_valid && (qr_page_4k != s_q.page_4k || qr_looped)
         |=> !link_on;
   endproperty
   a_qr_bad: assert property (p_qr_bad) else $error("invalid response brought link on");

   property p_no_mon;
      !s_q.lqm_en |-> !saturating && !s_q.checked;
   endproperty
   a_no_mon: assert property (p_no_mon) else $error("monitoring active while disabled");

   property p_qlvl_range;
      wr_qlvl && (reg_wdata[6:0] < `LQM_QLVL_MIN || reg_wdata[6:0] > `LQM_QLVL_MAX)
         && !soft_rst |=> $stable(s_q.qual_lvl);
   endproperty
   a_qlvl_range: assert property (p_qlvl_range) else $error("bad quality level taken");

   property p_win_range;
      wr_win && (reg_wdata[8:0] < `LQM_WIN_MIN || reg_wdata[8:0] > `LQM_WIN_MAX) && !soft_rst
         |=> $stable(s_q.win);
   endproperty
   a_win_range: assert property (p_win_range) else $error("bad window taken");

   property p_bad_out;
      in_service && s_q.lqm_en && check && (|bad_v) && !soft_rst && (s_q.mode == `LQM_MODE_ON)
         |=> !in_service;
   endproperty
   a_bad_out: assert property (p_bad_out) else $error("lossy line kept in service");

   property p_good_in;
      !in_service && s_q.checked && link_on && s_q.lqm_en && check && (&good_v) && !soft_rst
         && (s_q.mode == `LQM_MODE_ON) && !(s_q.idle_cnt == 24'(IDLE_CYC)) |=> in_service;
   endproperty
   a_good_in: assert property (p_good_in) else $error("recovered line not restored");

   property p_echo_len;
      send_echo |-> (echo_len == {2'b00, $past(s_q.rate[15:2])});
   endproperty
   a_echo_len: assert property (p_echo_len) else $error("echo length not line filling");

   property p_nuc_rst;
      nucleus_reset |=> !link_on && !in_service && (s_q.ista == 3'h0);
   endproperty
   a_nuc_rst: assert property (p_nuc_rst) else $error("reset command ignored");

   property p_svc_ev;
      !soft_rst && !nucleus_reset && (s_d.svc != s_q.svc) |=> s_q.ista[`LQM_IRQ_SVC_BIT];
   endproperty
   a_svc_ev: assert property (p_svc_ev) else $error("service change not flagged");
endmodule

// ---- lqm_remote_model.sv ----
`timescale 1ns/10ps
module lqm_remote_model (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        send_query,
   input  wire logic [3:0]  dly,
   input  wire logic        page_4k,
   input  wire logic        looped,
   input  wire logic [15:0] dest,
   input  wire logic [15:0] rep_rx_pkts,
   input  wire logic [15:0] rep_rx_bytes,
   input  wire logic [15:0] rep_tx_pkts,
   input  wire logic [15:0] rep_tx_bytes,
   output logic             qr_valid,
   output logic             link_activity,
   output logic [81:0]      qr_bus
);
   logic       pend_q;
   logic [3:0] wait_q;

   // fields toggle outside the answer cycle, so a late sample sees junk
   // window and quality level are the tb's own, so both ends agree by construction
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pend_q        <= 1'b0;
         wait_q        <= 4'h0;
         qr_valid      <= 1'b0;
         link_activity <= 1'b0;
         qr_bus        <= '0;
      end else begin
         qr_valid      <= 1'b0;
         link_activity <= 1'b0;
         qr_bus        <= ~qr_bus;
         if (send_query) begin
            pend_q <= 1'b1;
            wait_q <= dly;
         end else if (pend_q && wait_q != 4'h0) begin
            wait_q <= wait_q - 4'h1;
         end else if (pend_q) begin
            pend_q        <= 1'b0;
            qr_valid      <= 1'b1;
            link_activity <= 1'b1;
            qr_bus        <= {page_4k, looped, dest, rep_rx_pkts, rep_rx_bytes,
                              rep_tx_pkts, rep_tx_bytes};
         end
      end
   end
endmodule

// ---- lqm_top_tb.sv ----
`timescale 1ns/10ps
module lqm_top_tb;
   localparam int unsigned IDLE = 200;
   localparam int unsigned TICK = 20;
   localparam int unsigned ECHO = 10;
   logic        clk, reset_n, nucleus_reset, reg_wr, reg_rd, tx_pkt_done, rx_pkt_done;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rd_v;
   logic        link_activity, qr_valid, qr_page_4k, qr_looped, m_page, m_loop;
   logic [15:0] qr_dest, qr_rx_pkts, qr_rx_bytes, qr_tx_pkts, qr_tx_bytes, echo_len;
   logic [15:0] tx_pkt_len, rx_pkt_len, m_dest;
   logic [15:0] rep [4];
   logic [81:0] qr_bus;
   logic [3:0]  m_dly;
   logic        send_query, send_echo, link_on, in_service, saturating, irq;
   int          err_total, cmp_count, q0, t0, k;
   int          cyc = 0;
   int          q_seen = 0;
   int          last_act = 0;
   logic [7:0]  ra [8] = '{8'h04, 8'h04, 8'h04, 8'h04, 8'h08, 8'h08, 8'h08, 8'h08};
   logic [31:0] rv [8] = '{32'h09, 32'h0A, 32'h63, 32'h64, 32'h009, 32'h00A, 32'h190, 32'h191};
   logic [31:0] re [8] = '{32'h5A, 32'h0A, 32'h63, 32'h63, 32'h01E, 32'h00A, 32'h190, 32'h190};

   assign {qr_page_4k, qr_looped, qr_dest, qr_rx_pkts, qr_rx_bytes, qr_tx_pkts, qr_tx_bytes} = qr_bus;

   lqm_top #(.IDLE_CYC(IDLE), .TICK_CYC(TICK), .ECHO_CYC(ECHO)) dut (
      .clk(clk), .reset_n(reset_n), .nucleus_reset(nucleus_reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .link_activity(link_activity), .qr_valid(qr_valid), .qr_page_4k(qr_page_4k),
      .qr_looped(qr_looped), .qr_dest(qr_dest), .qr_rx_pkts(qr_rx_pkts),
      .qr_rx_bytes(qr_rx_bytes), .qr_tx_pkts(qr_tx_pkts), .qr_tx_bytes(qr_tx_bytes),
      .tx_pkt_done(tx_pkt_done), .tx_pkt_len(tx_pkt_len), .rx_pkt_done(rx_pkt_done),
      .rx_pkt_len(rx_pkt_len), .send_query(send_query), .send_echo(send_echo),
      .echo_len(echo_len), .link_on(link_on), .in_service(in_service),
      .saturating(saturating), .irq(irq));

   lqm_remote_model remote (
      .clk(clk), .reset_n(reset_n), .send_query(send_query), .dly(m_dly), .page_4k(m_page),
      .looped(m_loop), .dest(m_dest), .rep_rx_pkts(rep[0]), .rep_rx_bytes(rep[1]),
      .rep_tx_pkts(rep[2]), .rep_tx_bytes(rep[3]), .qr_valid(qr_valid),
      .link_activity(link_activity), .qr_bus(qr_bus));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (send_query === 1'b1) q_seen <= q_seen + 1;
      if (qr_valid === 1'b1) last_act <= cyc;
   end

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 rd_v = reg_rdata;
   endtask

   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
      rd(a);
      chk(nm, exp, rd_v);
   endtask

   task automatic wait_on(input logic exp, input int lim);
      int n;
      n = 0;
      while (link_on !== exp && n < lim) begin
         @(posedge clk);
         #1 n++;
      end
   endtask

   // polls the check-done flag; reads cost two cycles, so timing is coarse
   task automatic wait_check;
      int n;
      n = 0;
      wr(8'h18, 32'h4);
      rd(8'h18);
      while (rd_v[2] !== 1'b1 && n < 200) begin
         rd(8'h18);
         n++;
      end
      chk("check_done", 1, {31'h0, rd_v[2]});
   endtask

   task automatic window(input logic [15:0] r0, r1, r2, r3);
      @(posedge clk);
      rep <= '{r0, r1, r2, r3};
      wait_check;
      repeat (100) begin
         @(posedge clk);
         tx_pkt_done <= 1'b1;
         rx_pkt_done <= 1'b1;
      end
      @(posedge clk);
      tx_pkt_done <= 1'b0;
      rx_pkt_done <= 1'b0;
      wait_check;
   endtask

   task automatic wait_echo;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         #1 n++;
      end while (send_echo !== 1'b1 && n < 4 * ECHO);
   endtask

   task wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      repeat (40000) @(posedge clk);
      err_total++;
      wrap_up;
   end

   initial begin
      err_total = 0;
      cmp_count = 0;
      reset_n = 1'b0;
      nucleus_reset = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      tx_pkt_done = 1'b0;
      rx_pkt_done = 1'b0;
      tx_pkt_len = 16'h0001;
      rx_pkt_len = 16'h0001;
      m_page = 1'b0;
      m_loop = 1'b0;
      m_dest = 16'h1234;
      m_dly = 4'h1;
      rep = '{default: 16'h0000};
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      rchk("ctrl", 8'h00, 32'h0);
      rchk("qlvl", 8'h04, 32'h5A);
      rchk("win", 8'h08, 32'h1E);
      rchk("status", 8'h14, 32'h0);
      rchk("unmapped", 8'h20, 32'h0);
      for (k = 0; k < 8; k++) begin
         wr(ra[k], rv[k]);
         rchk("range", ra[k], re[k]);
      end
      wr(8'h14, 32'hFF);
      rchk("status_ro", 8'h14, 32'h0);
      wr(8'h04, 32'h5A);
      wr(8'h08, 32'h0A);
      wr(8'h0C, 32'h1234);
      wr(8'h10, 32'h1000);
      // each refused answer breaks exactly one condition of a valid response
      for (k = 0; k < 3; k++) begin
         @(posedge clk);
         m_page <= (k == 0);
         m_loop <= (k == 1);
         m_dest <= (k == 2) ? 16'h4321 : 16'h1234;
         if (k == 0) wr(8'h00, 32'h3);
         q0 = q_seen;
         repeat (3 * TICK) @(posedge clk);
         chk("query_neg", 1, {31'h0, q_seen > q0});
         chk("refused", 0, {31'h0, link_on});
      end
      @(posedge clk);
      m_page <= 1'b0;
      m_loop <= 1'b0;
      m_dest <= 16'h1234;
      m_dly <= 4'h9;
      wait_on(1'b1, 3 * TICK + 20);
      chk("link_on", 1, {31'h0, link_on});
      @(posedge clk);
      #1 chk("svc_nomon", 1, {31'h0, in_service});
      chk("irq_masked", 0, {31'h0, irq});
      rd(8'h18);
      chk("irq_svc", 1, {31'h0, rd_v[0]});
      wr(8'h1C, 32'h3);
      #1 chk("irq_up", 1, {31'h0, irq});
      wr(8'h18, 32'h3);
      #1 chk("irq_clr", 0, {31'h0, irq});
      q0 = q_seen;
      repeat (3 * TICK) @(posedge clk);
      chk("no_query", 0, {31'h0, q_seen != q0});
      wait_on(1'b0, IDLE + 20);
      chk("idle_drop", 1, {31'h0, (cyc - last_act >= IDLE) && (cyc - last_act <= IDLE + 3)});
      @(posedge clk);
      m_dly <= 4'h1;
      wr(8'h00, 32'h7);
      wait_on(1'b1, 3 * TICK + 20);
      q0 = q_seen;
      wait_check;
      t0 = cyc;
      wait_check;
      chk("period", 1, {31'h0, (cyc - t0 >= 10 * TICK - 6) && (cyc - t0 <= 10 * TICK + 6)});
      chk("query_mon", 1, {31'h0, q_seen > q0});
      chk("svc_first", 1, {31'h0, in_service});
      wr(8'h1C, 32'h1);
      for (k = 0; k < 4; k++) begin
         window((k == 0) ? 16'd90 : 16'd100, (k == 1) ? 16'd90 : 16'd100,
                (k == 2) ? 16'd112 : 16'd100, (k == 3) ? 16'd112 : 16'd100);
         rchk("status_bad", 8'h14, 32'h5 | (32'h8 << k));
         chk("irq_out", 1, {31'h0, irq});
         chk("sat_out", 1, {31'h0, saturating});
         wr(8'h18, 32'h1);
         if (k == 0) begin
            wait_echo;
            t0 = cyc;
            wait_echo;
            chk("echo_gap", ECHO, cyc - t0);
            chk("echo_len", 32'h0400, {16'h0, echo_len});
            window(16'd93, 16'd100, 16'd100, 16'd100);
            rchk("no_restore", 8'h14, 32'h5);
         end
         window((k == 0) ? 16'd94 : 16'd100, 16'd100, 16'd100, 16'd100);
         rchk("restored", 8'h14, 32'h3);
         wr(8'h18, 32'h1);
      end
      wr(8'h00, 32'h10);
      rchk("win_srst", 8'h08, 32'h1E);
      chk("link_srst", 0, {31'h0, link_on});
      wr(8'h04, 32'h20);
      @(posedge clk);
      nucleus_reset <= 1'b1;
      @(posedge clk);
      nucleus_reset <= 1'b0;
      rchk("qlvl_nrst", 8'h04, 32'h5A);
      wrap_up;
   end
endmodule
